// >>> cplc_pkg.sv
// Shared constants and types for the clock, power and low-power controller
package cplc_pkg;
  // ==========================================================================
  // Register map
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [7:0] CLR_OFF = 8'h08;
  localparam logic [7:0] RISE_OFF = 8'h0c;
  localparam logic [7:0] FALL_OFF = 8'h10;
  localparam logic [7:0] MASK_OFF = 8'h14;
  localparam logic [7:0] PEND_OFF = 8'h18;
  localparam logic [7:0] CMD_OFF = 8'h1c;
  // Flag positions shared by status and clear registers
  localparam int CLR_CSS = 6;
  localparam int CLR_PLL = 7;
  localparam int CLR_PVDF = 8;
  localparam int CLR_PVDR = 9;
  // ==========================================================================
  // Clock figures
  localparam int INT_RC_MHZ = 8;
  localparam int EXT_MIN_MHZ = 4;
  localparam int EXT_MAX_MHZ = 16;
  localparam int AHB_MAX_MHZ = 72;
  localparam int HSPB_MAX_MHZ = 72;
  localparam int LSPB_MAX_MHZ = 36;
  localparam int CLK_PERIOD_NS = 4;
  localparam int CSS_TIMEOUT_NS = 2000;
  localparam int CSS_CYC = CSS_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int DIV_W = 8;
  localparam int MISS_W = 12;
  localparam int LINES = 19;
  localparam int EXT_LINES = 16;
  // ==========================================================================
  // Commands and encodings
  localparam logic [1:0] CMD_SLEEP = 2'h1;
  localparam logic [1:0] CMD_STOP = 2'h2;
  localparam logic [1:0] CMD_STBY = 2'h3;
  localparam logic [1:0] BOOT_FLASH = 2'h0;
  localparam logic [1:0] BOOT_SYSMEM = 2'h1;
  localparam logic [1:0] BOOT_SRAM = 2'h2;
  typedef enum logic [1:0] {SRC_INT, SRC_EXT, SRC_PLL, SRC_RSV} cplc_src_type;
  typedef enum logic [1:0] {MD_RUN, MD_SLEEP, MD_STOP, MD_STBY} cplc_mode_type;
  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [2:0] pvdLevel;
    logic pllOn;
    logic hseOn;
    logic stopLp;
    logic pvdRiseIe;
    logic pvdFallIe;
    logic pvdEn;
    logic pllIe;
    logic cssIe;
    logic [1:0] lspbDiv;
    logic [1:0] hspbDiv;
    logic [1:0] ahbDiv;
    cplc_src_type clkSel;
  } cplc_ctrl_type;
  localparam cplc_ctrl_type CTRL_RST = 19'h00000;
  typedef struct packed {
    logic cpu;
    logic ahb;
    logic hspb;
    logic lspb;
  } cplc_clken_type;
  typedef struct packed {
    logic intRc;
    logic extOsc;
    logic pll;
    logic lowRc;
  } cplc_osc_type;
endpackage

// >>> cplc_edge_lines.sv
// Edge detecting, maskable wakeup lines with sticky pending flags
`timescale 1ns/1ps
module cplc_edge_lines #(
  parameter int N = 19
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [N-1:0] lines,
  input wire logic [N-1:0] rise,
  input wire logic [N-1:0] fall,
  input wire logic [N-1:0] mask,
  input wire logic [N-1:0] clr,
  output logic [N-1:0] pend
);
  logic [N-1:0] prev_r;
  logic [N-1:0] hit;

  if (N < 1)
  begin : g_chk
    $error("cplc_edge_lines needs at least one line");
  end

  // ==========================================================================
  // Detection
  assign hit = mask & ((rise & lines & ~prev_r) | (fall & ~lines & prev_r));

  always_ff @(posedge core_clk)
  begin
    if (rst)
      prev_r <= '0;
    else
      prev_r <= lines;
  end

  // Set beats clear so no edge is lost
  always_ff @(posedge core_clk)
  begin
    if (rst)
      pend <= '0;
    else
      pend <= (pend & ~clr) | hit;
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_edgeSets;
    hit != '0 |=> (pend & $past(hit)) == $past(hit);
  endproperty
  a_edgeSets: assert property (p_edgeSets) else $error("edge did not set pending");
  property p_maskedQuiet;
    (mask == '0) && (pend == '0) |=> pend == '0;
  endproperty
  a_maskedQuiet: assert property (p_maskedQuiet) else $error("masked line set pending");
endmodule

// >>> cplc_ctrl.sv
// Clock selection, supply supervision and low-power sequencing controller
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module cplc_ctrl
  import cplc_pkg::*;
#(
  parameter int EXT_MHZ = 8,
  parameter int PLL_MHZ = 72
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic porOk,
  input wire logic extResetPinN,
  input wire logic iwdgReset,
  input wire logic wakeupPin,
  input wire logic [1:0] bootPins,
  input wire logic extOscBeat,
  input wire logic pllLock,
  input wire logic pvdBelow,
  input wire logic [EXT_LINES-1:0] extLines,
  input wire logic rtcAlarm,
  input wire logic usbWake,
  input wire logic cpuIrq,
  output logic coreRst,
  output logic [1:0] bootSel,
  output cplc_clken_type clkEn,
  output cplc_osc_type oscEn,
  output logic regMain,
  output logic regLowPower,
  output logic regOff,
  output logic [2:0] pvdThresh,
  output logic clkFailIrq,
  output logic pvdIrq,
  output logic extiIrq
);
  // ==========================================================================
  // Checks and helpers
  if (EXT_MHZ < EXT_MIN_MHZ || EXT_MHZ > EXT_MAX_MHZ || PLL_MHZ < 1)
  begin : g_chk
    $error("cplc_ctrl clock parameters out of range");
  end

  function automatic int srcMhz(input cplc_src_type s);
    case (s)
      SRC_EXT: return EXT_MHZ;
      SRC_PLL: return PLL_MHZ;
      default: return INT_RC_MHZ;
    endcase
  endfunction

  // A setting that would overclock AHB or the fast bus is refused
  function automatic logic freqOk(input cplc_ctrl_type c);
    int ahb;
    ahb = srcMhz(c.clkSel) >> c.ahbDiv;
    return (ahb <= AHB_MAX_MHZ) && ((ahb >> c.hspbDiv) <= HSPB_MAX_MHZ);
  endfunction

  function automatic logic isTick(input logic [DIV_W-1:0] cnt, input int sh);
    logic [DIV_W-1:0] m;
    m = DIV_W'((1 << sh) - 1);
    return (cnt & m) == '0;
  endfunction

  // ==========================================================================
  // Declarations
  cplc_ctrl_type ctrl_r;
  cplc_src_type activeSrc_r;
  cplc_mode_type mode_r;
  logic resetReq_r;
  logic rstAll;
  logic wkPrev_r;
  logic stbyWake;
  logic wrEn;
  logic rdEn;
  logic mapped;
  logic [MISS_W-1:0] miss_r;
  logic beatPrev_r;
  logic extDead;
  logic cssEvt;
  logic pllEvt;
  logic cssFlag_r;
  logic pllFlag_r;
  logic pvdFall_r;
  logic pvdRise_r;
  logic pvdPrev_r;
  logic pvdOut;
  logic [LINES-1:0] rise_r;
  logic [LINES-1:0] fall_r;
  logic [LINES-1:0] mask_r;
  logic [LINES-1:0] pend;
  logic [LINES-1:0] pendClr;
  logic extiAny;
  logic stopWake;
  logic [DIV_W-1:0] div_r;
  logic lowPwr;
  logic [31:0] rdVal;

  // ==========================================================================
  // Reset generation
  assign stbyWake = (mode_r == MD_STBY) && (rtcAlarm || (wakeupPin && !wkPrev_r));

  // Supply, pin and watchdog resets act in every mode, standby included
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      resetReq_r <= 1'b1;
      wkPrev_r <= 1'b0;
    end
    else
    begin
      resetReq_r <= !porOk || !extResetPinN || iwdgReset || stbyWake;
      wkPrev_r <= wakeupPin;
    end
  end

  assign rstAll = sys_rst || resetReq_r;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      coreRst <= 1'b1;
    else
      coreRst <= rstAll;
  end

  // Boot pins caught on the first cycle after reset release
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      bootSel <= BOOT_FLASH;
    else if (coreRst && !rstAll)
    begin
      if (!bootPins[0])
        bootSel <= BOOT_FLASH;
      else if (!bootPins[1])
        bootSel <= BOOT_SYSMEM;
      else
        bootSel <= BOOT_SRAM;
    end
  end

  // ==========================================================================
  // Bus slave: one wait state, so read data can come from a flip-flop
  assign wrEn = psel && penable && pready && pwrite;
  assign rdEn = psel && penable && !pready && !pwrite;
  assign mapped = paddr inside {CTRL_OFF, STAT_OFF, CLR_OFF, RISE_OFF, FALL_OFF, MASK_OFF, PEND_OFF, CMD_OFF};

  always_comb
  begin
    case (paddr)
      CTRL_OFF: rdVal = {13'h0000, ctrl_r};
      STAT_OFF: rdVal = {21'h000000, pvdOut, pvdRise_r, pvdFall_r, pllFlag_r, cssFlag_r, mode_r, bootSel, activeSrc_r};
      RISE_OFF: rdVal = {13'h0000, rise_r};
      FALL_OFF: rdVal = {13'h0000, fall_r};
      MASK_OFF: rdVal = {13'h0000, mask_r};
      PEND_OFF: rdVal = {13'h0000, pend};
      default: rdVal = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rstAll)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && penable && !pready;
      if (rdEn)
        prdata <= rdVal;
      if (psel && penable && !pready)
        pslverr <= !mapped || (pwrite && paddr == CTRL_OFF && !freqOk(cplc_ctrl_type'(pwdata[18:0])));
      else
        pslverr <= 1'b0;
    end
  end

  // ==========================================================================
  // Clock source selection and failure monitor
  assign extDead = miss_r == MISS_W'(CSS_CYC);
  assign cssEvt = activeSrc_r == SRC_EXT && extDead && mode_r != MD_STOP;
  assign pllEvt = activeSrc_r == SRC_PLL && !pllLock && mode_r != MD_STOP;
  assign stopWake = mode_r == MD_STOP && extiAny;

  // Beat must toggle within the timeout while the oscillator is enabled
  always_ff @(posedge core_clk)
  begin
    if (rstAll)
    begin
      miss_r <= '0;
      beatPrev_r <= 1'b0;
    end
    else
    begin
      beatPrev_r <= extOscBeat;
      if (!ctrl_r.hseOn || extOscBeat != beatPrev_r)
        miss_r <= '0;
      else if (!extDead)
        miss_r <= miss_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rstAll)
    begin
      ctrl_r <= CTRL_RST;
      activeSrc_r <= SRC_INT;
    end
    else if (cssEvt || pllEvt || stopWake)
    begin
      ctrl_r.clkSel <= SRC_INT;
      activeSrc_r <= SRC_INT;
      if (stopWake)
      begin
        ctrl_r.hseOn <= 1'b0;
        ctrl_r.pllOn <= 1'b0;
      end
    end
    else
    begin
      if (wrEn && paddr == CTRL_OFF && freqOk(cplc_ctrl_type'(pwdata[18:0])))
        ctrl_r <= cplc_ctrl_type'(pwdata[18:0]);
      if (ctrl_r.clkSel == SRC_INT)
        activeSrc_r <= SRC_INT;
      else if (ctrl_r.clkSel == SRC_EXT && ctrl_r.hseOn && !extDead)
        activeSrc_r <= SRC_EXT;
      else if (ctrl_r.clkSel == SRC_PLL && ctrl_r.pllOn && pllLock)
        activeSrc_r <= SRC_PLL;
    end
  end

  // ==========================================================================
  // Sticky flags: a set in the clearing cycle wins
  assign pvdOut = ctrl_r.pvdEn && pvdBelow;

  always_ff @(posedge core_clk)
  begin
    if (rstAll)
    begin
      cssFlag_r <= 1'b0;
      pllFlag_r <= 1'b0;
      pvdFall_r <= 1'b0;
      pvdRise_r <= 1'b0;
      pvdPrev_r <= 1'b0;
    end
    else
    begin
      pvdPrev_r <= pvdOut;
      cssFlag_r <= (cssFlag_r && !(wrEn && paddr == CLR_OFF && pwdata[CLR_CSS])) || cssEvt;
      pllFlag_r <= (pllFlag_r && !(wrEn && paddr == CLR_OFF && pwdata[CLR_PLL])) || pllEvt;
      pvdFall_r <= (pvdFall_r && !(wrEn && paddr == CLR_OFF && pwdata[CLR_PVDF])) || (pvdOut && !pvdPrev_r);
      pvdRise_r <= (pvdRise_r && !(wrEn && paddr == CLR_OFF && pwdata[CLR_PVDR])) || (!pvdOut && pvdPrev_r && ctrl_r.pvdEn);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rstAll)
    begin
      clkFailIrq <= 1'b0;
      pvdIrq <= 1'b0;
      extiIrq <= 1'b0;
    end
    else
    begin
      clkFailIrq <= (cssFlag_r && ctrl_r.cssIe) || (pllFlag_r && ctrl_r.pllIe);
      pvdIrq <= (pvdFall_r && ctrl_r.pvdFallIe) || (pvdRise_r && ctrl_r.pvdRiseIe);
      extiIrq <= extiAny;
    end
  end

  // ==========================================================================
  // Wakeup lines: pins, supply detector, alarm, USB
  always_ff @(posedge core_clk)
  begin
    if (rstAll)
    begin
      rise_r <= '0;
      fall_r <= '0;
      mask_r <= '0;
    end
    else if (wrEn)
    begin
      if (paddr == RISE_OFF)
        rise_r <= pwdata[LINES-1:0];
      if (paddr == FALL_OFF)
        fall_r <= pwdata[LINES-1:0];
      if (paddr == MASK_OFF)
        mask_r <= pwdata[LINES-1:0];
    end
  end

  assign pendClr = (wrEn && paddr == PEND_OFF) ? pwdata[LINES-1:0] : '0;
  assign extiAny = |pend;

  cplc_edge_lines #(
    .N(LINES)
  ) u_lines (
    .core_clk(core_clk),
    .rst(rstAll),
    .lines({usbWake, rtcAlarm, pvdOut, extLines}),
    .rise(rise_r),
    .fall(fall_r),
    .mask(mask_r),
    .clr(pendClr),
    .pend(pend)
  );

  // ==========================================================================
  // Power mode sequencing
  always_ff @(posedge core_clk)
  begin
    if (rstAll)
      mode_r <= MD_RUN;
    else
    begin
      case (mode_r)
        MD_RUN:
        begin
          if (wrEn && paddr == CMD_OFF)
          begin
            if (pwdata[1:0] == CMD_SLEEP)
              mode_r <= MD_SLEEP;
            else if (pwdata[1:0] == CMD_STOP)
              mode_r <= MD_STOP;
            else if (pwdata[1:0] == CMD_STBY)
              mode_r <= MD_STBY;
          end
        end
        MD_SLEEP:
          if (cpuIrq || extiAny)
            mode_r <= MD_RUN;
        MD_STOP:
          if (extiAny)
            mode_r <= MD_RUN;
        MD_STBY:
          mode_r <= MD_STBY; // Left only through the reset path
        default:
          mode_r <= MD_RUN;
      endcase
    end
  end

  // ==========================================================================
  // Clock enables, oscillators and regulator
  assign lowPwr = mode_r == MD_STOP || mode_r == MD_STBY;

  always_ff @(posedge core_clk)
  begin
    if (rstAll)
      div_r <= '0;
    else
      div_r <= div_r + 1'b1;
  end

  // Buses tick from one counter so slower domains stay aligned to AHB
  always_ff @(posedge core_clk)
  begin
    if (rstAll)
    begin
      clkEn <= '0;
      oscEn <= 4'h9;
      regMain <= 1'b1;
      regLowPower <= 1'b0;
      regOff <= 1'b0;
      pvdThresh <= 3'h0;
    end
    else
    begin
      clkEn.cpu <= mode_r == MD_RUN && isTick(div_r, int'(ctrl_r.ahbDiv));
      clkEn.ahb <= !lowPwr && isTick(div_r, int'(ctrl_r.ahbDiv));
      clkEn.hspb <= !lowPwr && isTick(div_r, int'(ctrl_r.ahbDiv) + int'(ctrl_r.hspbDiv));
      clkEn.lspb <= !lowPwr && isTick(div_r, int'(ctrl_r.ahbDiv) + int'(ctrl_r.lspbDiv));
      oscEn.intRc <= !lowPwr;
      oscEn.extOsc <= !lowPwr && ctrl_r.hseOn;
      oscEn.pll <= !lowPwr && ctrl_r.pllOn;
      oscEn.lowRc <= 1'b1;
      regMain <= !lowPwr || (mode_r == MD_STOP && !ctrl_r.stopLp);
      regLowPower <= mode_r == MD_STOP && ctrl_r.stopLp;
      regOff <= mode_r == MD_STBY;
      pvdThresh <= ctrl_r.pvdLevel;
    end
  end

  // ==========================================================================
  // Checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (rstAll);

  property p_rcAfterReset;
    $fell(coreRst) |-> activeSrc_r == SRC_INT && mode_r == MD_RUN;
  endproperty
  a_rcAfterReset: assert property (p_rcAfterReset) else $error("not on RC after reset");

  property p_cssFallback;
    cssEvt |=> activeSrc_r == SRC_INT && cssFlag_r ##1 oscEn.intRc;
  endproperty
  a_cssFallback: assert property (p_cssFallback) else $error("no fallback on clock failure");

  property p_cssIrq;
    cssEvt && ctrl_r.cssIe |-> ##2 clkFailIrq;
  endproperty
  a_cssIrq: assert property (p_cssIrq) else $error("clock failure irq missing");

  property p_pllLoss;
    pllEvt |=> pllFlag_r && activeSrc_r == SRC_INT;
  endproperty
  a_pllLoss: assert property (p_pllLoss) else $error("pll loss not handled");

  property p_freqLimit;
    freqOk(ctrl_r);
  endproperty
  a_freqLimit: assert property (p_freqLimit) else $error("bus clock above limit");

  property p_porHold;
    @(posedge core_clk) disable iff (sys_rst) !porOk |-> ##2 coreRst;
  endproperty
  a_porHold: assert property (p_porHold) else $error("low supply not holding reset");

  property p_stbyReg;
    mode_r == MD_STBY |=> regOff && !regMain && !oscEn.extOsc && !oscEn.pll;
  endproperty
  a_stbyReg: assert property (p_stbyReg) else $error("standby power not off");

  property p_sleepCpu;
    mode_r == MD_SLEEP && $past(mode_r) == MD_SLEEP |-> !clkEn.cpu;
  endproperty
  a_sleepCpu: assert property (p_sleepCpu) else $error("cpu clock runs in sleep");

  property p_stopOsc;
    mode_r == MD_STOP |=> !oscEn.intRc && !clkEn.ahb && oscEn.lowRc;
  endproperty
  a_stopOsc: assert property (p_stopOsc) else $error("stop left clocks running");

  property p_stopWake;
    stopWake |=> mode_r == MD_RUN && activeSrc_r == SRC_INT && !ctrl_r.pllOn;
  endproperty
  a_stopWake: assert property (p_stopWake) else $error("stop wake not on RC");

  property p_stbyExit;
    @(posedge core_clk) disable iff (sys_rst) stbyWake |-> ##2 coreRst;
  endproperty
  a_stbyExit: assert property (p_stbyExit) else $error("standby wake gave no reset");
endmodule

// >>> cplc_far_model.sv
// Far-side model: external oscillator beat and PLL lock
`timescale 1ns/1ps
module cplc_far_model
  import cplc_pkg::*;
(
  input wire logic core_clk,
  input wire cplc_osc_type oscEn,
  input wire logic oscDead,
  output logic extOscBeat,
  output logic pllLock
);
  // ==========================================================================
  // Oscillator behaviour
  initial
  begin
    extOscBeat = 1'b0;
    pllLock = 1'b0;
  end
  // Dead crystal sticks at its last level; only change is watched
  always @(posedge core_clk)
  begin
    if (oscEn.extOsc && !oscDead)
    begin
      extOscBeat <= ~extOscBeat;
    end
  end
  // Lock trails enable by one cycle; a dead reference drops it
  always @(posedge core_clk)
  begin
    pllLock <= oscEn.pll && !oscDead;
  end
endmodule

// >>> cplc_ctrl_tb.sv
// Self-checking bench for the clock, power and low-power controller
`timescale 1ns/1ps
module cplc_ctrl_tb
  import cplc_pkg::*;
;
  // ==========================================================================
  // Stimulus and wiring
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic porOk = 1'b1;
  logic extResetPinN = 1'b1;
  logic iwdgReset = 1'b0;
  logic wakeupPin = 1'b0;
  logic [1:0] bootPins = 2'b01;
  logic extOscBeat;
  logic pllLock;
  logic pvdBelow = 1'b0;
  logic [EXT_LINES-1:0] extLines = 16'h0;
  logic rtcAlarm = 1'b0;
  logic usbWake = 1'b0;
  logic cpuIrq = 1'b0;
  logic oscDead = 1'b0;
  logic coreRst;
  logic [1:0] bootSel;
  cplc_clken_type clkEn;
  cplc_osc_type oscEn;
  logic regMain;
  logic regLowPower;
  logic regOff;
  logic [2:0] pvdThresh;
  logic clkFailIrq;
  logic pvdIrq;
  logic extiIrq;
  logic [31:0] rd;
  logic er;
  int nErrors = 0;
  int checked = 0;
  always #2 core_clk = ~core_clk;
  // PLL faster than the bus limit so a refused divider can be tried
  cplc_ctrl #(.EXT_MHZ(8), .PLL_MHZ(144)) cplc_ctrl_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .porOk(porOk), .extResetPinN(extResetPinN),
    .iwdgReset(iwdgReset), .wakeupPin(wakeupPin), .bootPins(bootPins), .extOscBeat(extOscBeat),
    .pllLock(pllLock), .pvdBelow(pvdBelow), .extLines(extLines), .rtcAlarm(rtcAlarm),
    .usbWake(usbWake), .cpuIrq(cpuIrq), .coreRst(coreRst), .bootSel(bootSel), .clkEn(clkEn),
    .oscEn(oscEn), .regMain(regMain), .regLowPower(regLowPower), .regOff(regOff),
    .pvdThresh(pvdThresh), .clkFailIrq(clkFailIrq), .pvdIrq(pvdIrq), .extiIrq(extiIrq));
  cplc_far_model cplc_far_model_inst (.core_clk(core_clk), .oscEn(oscEn), .oscDead(oscDead),
    .extOscBeat(extOscBeat), .pllLock(pllLock));
  // ==========================================================================
  // Shared tasks
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      nErrors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bounded wait on pready; no fixed latency assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge core_clk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20)
      chk("pready", 1, 0);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    tick(3);
    chk("coreRst", 0, coreRst);
    chk("bootSel", BOOT_SYSMEM, bootSel);
    chk("oscEn", 4'h9, oscEn);
    chk("regMode", 3'h4, {regMain, regLowPower, regOff});
    apb(0, STAT_OFF, 0);
    chk("stat", 32'h4, rd);
  endtask
  task automatic t_refuse;
    apb(1, CTRL_OFF, 32'h8002);
    chk("ctrlErr", 1, er);
    apb(0, CTRL_OFF, 0);
    chk("ctrlKept", 0, rd);
    apb(1, CTRL_OFF, 32'h8046);
    chk("ctrlOkErr", 0, er);
    tick(5);
    apb(0, STAT_OFF, 0);
    chk("srcPll", SRC_PLL, rd[1:0]);
    oscDead <= 1'b1;
    tick(4);
    apb(0, STAT_OFF, 0);
    chk("pllLoss", 32'h84, rd);
    apb(1, CLR_OFF, 32'h80);
    oscDead <= 1'b0;
    apb(0, 8'h20, 0);
    chk("unmapErr", 1, er);
    chk("unmapRd", 0, rd);
  endtask
  task automatic t_stop;
    apb(1, CTRL_OFF, 32'h6001);
    apb(1, RISE_OFF, 32'h8);
    apb(1, MASK_OFF, 32'h8);
    apb(1, CMD_OFF, CMD_STOP);
    tick(3);
    chk("stopOsc", 4'h1, oscEn);
    chk("stopClk", 0, clkEn);
    chk("stopReg", 3'h2, {regMain, regLowPower, regOff});
    extLines <= 16'h8;
    for (int i = 0; i < 10 && oscEn.intRc !== 1'b1; i++)
      tick(1);
    apb(0, STAT_OFF, 0);
    chk("stopWake", 0, {rd[5:4], rd[1:0]});
    apb(0, CTRL_OFF, 0);
    chk("extOff", 0, rd[14]);
    apb(0, PEND_OFF, 0);
    chk("pend", 32'h8, rd);
    chk("extiIrq", 1, extiIrq);
    apb(1, PEND_OFF, 32'h8);
    extLines <= 16'h0;
  endtask
  task automatic t_fail;
    apb(1, CTRL_OFF, 32'h4101);
    tick(5);
    oscDead <= 1'b1;
    for (int i = 0; i < 700 && clkFailIrq !== 1'b1; i++)
      tick(1);
    chk("failIrq", 1, clkFailIrq);
    apb(0, STAT_OFF, 0);
    chk("failStat", 32'h44, rd);
    apb(1, CLR_OFF, 32'h40);
    tick(3);
    chk("failClr", 0, clkFailIrq);
    oscDead <= 1'b0;
  endtask
  task automatic t_sleep;
    apb(1, CMD_OFF, CMD_SLEEP);
    tick(3);
    chk("sleepCpu", 2'h1, {clkEn.cpu, clkEn.ahb});
    cpuIrq <= 1'b1;
    tick(4);
    chk("sleepWake", 1, clkEn.cpu);
    cpuIrq <= 1'b0;
  endtask
  task automatic t_pvd;
    apb(1, CTRL_OFF, 32'h50c00);
    tick(2);
    chk("thresh", 3'h5, pvdThresh);
    pvdBelow <= 1'b1;
    tick(4);
    chk("pvdIrq", 1, pvdIrq);
    pvdBelow <= 1'b0;
  endtask
  task automatic t_stby;
    bootPins <= 2'b11;
    apb(1, CMD_OFF, CMD_STBY);
    tick(3);
    chk("stbyReg", 3'h1, {regMain, regLowPower, regOff});
    chk("stbyOsc", 4'h1, oscEn);
    wakeupPin <= 1'b1;
    for (int i = 0; i < 8 && coreRst !== 1'b1; i++)
      tick(1);
    chk("stbyRst", 1, coreRst);
    for (int i = 0; i < 8 && coreRst !== 1'b0; i++)
      tick(1);
    chk("stbyBoot", BOOT_SRAM, bootSel);
    chk("stbyOscOn", 4'h9, oscEn);
  endtask
  // Low supply in mid-run: reset held, then a second release
  task automatic t_por;
    porOk <= 1'b0;
    tick(4);
    chk("porRst", 1, coreRst);
    porOk <= 1'b1;
    tick(4);
    chk("porRel", 0, coreRst);
  endtask
  // ==========================================================================
  // Verdict, watchdog and main sequence
  task automatic give_verdict;
    $display("checks %0d errors %0d", checked, nErrors);
    if (nErrors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #40000;
    nErrors++;
    give_verdict();
  end
  initial
  begin
    tick(3);
    sys_rst <= 1'b0;
    t_reset();
    t_refuse();
    t_stop();
    t_fail();
    t_sleep();
    t_pvd();
    t_stby();
    t_por();
    give_verdict();
  end
endmodule
